/* File: shc_service_hours.sv */
// Service hours counter: run time, time-to-go, alarm, Avalon-MM registers
// Operation
// R01: Rising partial reset clears alarm and reloads time-to-go from interval.
// R02: Partial reset leaves accumulated run time untouched.
// R03: Rising full reset clears alarm, clears run time, reloads time-to-go.
// R04: Run input high advances run time and lowers time-to-go; low freezes both.
// R05: Alarm is set once time-to-go reaches zero.
// R06: Clear-on-run mode: either reset high or run low clears alarm.
// R07: Clear-on-reset mode: only a reset level clears alarm.
// R08: Interval accepts 0..9999 hours and 0..59 minutes.
// R09: Run time offset may be preset in programming mode.
// R10: Run time saturates and holds at 99999 hours.
// R11: Run time keeps counting while run is high, whatever partial reset does.
// R12: Without any partial reset, time-to-go is interval minus run time mod interval.
// R13: No run time preset at runtime; interval change copies into time-to-go.
// R14: Interval, time-to-go and run time are retained across power loss; here rst_n clears all three to zero.
// R15: Interval may come live from another block's value instead of a constant.
// R16: Minute tick timebase; minutes wrap 59 to 0; time-to-go stops at zero.
`timescale 1ns/1ps
`include "shc_params.svh"
module shc_service_hours
    import shc_pkg::*;
#(
    parameter longint unsigned MINUTE_CYCLES = `SHC_MINUTE_S * `SHC_CLK_HZ
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Inputs from other program blocks
    input  wire logic        runMonitorIn,
    input  wire logic        partialReset,
    input  wire logic        fullReset,
    input  wire logic [13:0] extIntervalHours,
    input  wire logic [5:0]  extIntervalMins,
    // Alarm output
    output logic             alarmOut
);
    localparam int DIV_W = $clog2(MINUTE_CYCLES + 64'h1);

    shc_state_s  s_q;
    shc_state_s  s_d;
    logic        partialRise;
    logic        fullRise;
    logic        busReq;
    logic        busWrite;
    logic        accWrite;
    logic        countEn;
    logic        accumSat;
    logic        miChange;
    logic        progFall;
    logic        clearCond;
    logic [31:0] beMask;
    logic [31:0] wval;
    shc_ival_s   miEff;
    shc_ival_s   recalc;
    shc_accum_s  accWrVal;
    logic [19:0] miMin;
    logic [22:0] otMin;
    logic [19:0] remMin;

    shc_tick_if tickIf ();

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // Clamp a written interval word into range
    function automatic shc_ival_s clampIval(input logic [31:0] w);
        shc_ival_s v;
        v.hours = (w[13:0] > `SHC_IVAL_HOURS_MAX) ? `SHC_IVAL_HOURS_MAX : w[13:0];
        v.mins  = (w[`SHC_HM_MINS_LSB +: 6] > `SHC_MINS_MAX) ? `SHC_MINS_MAX
                                                             : w[`SHC_HM_MINS_LSB +: 6];
        return v;
    endfunction : clampIval

    // Clamp a written run time word into range
    function automatic shc_accum_s clampAccum(input logic [31:0] w);
        shc_accum_s v;
        v.hours = (w[16:0] > `SHC_ACCUM_HOURS_MAX) ? `SHC_ACCUM_HOURS_MAX : w[16:0];
        v.mins  = (w[`SHC_ACC_MINS_LSB +: 6] > `SHC_MINS_MAX) ? `SHC_MINS_MAX
                                                              : w[`SHC_ACC_MINS_LSB +: 6];
        return v;
    endfunction : clampAccum

    // Read view of one register
    function automatic logic [31:0] readValue(input logic [4:0] a, input shc_state_s s,
                                              input logic run);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `SHC_ADDR_CTRL:
            begin
                v[`SHC_CTRL_PROG_BIT] = s.progMode;
                v[`SHC_CTRL_MODE_BIT] = (s.clrMode == SHC_CLR_RESET_ONLY);
                v[`SHC_CTRL_EXT_BIT]  = s.extSelect;
            end
            `SHC_ADDR_INTERVAL:
            begin
                v[13:0]                    = s.interval.hours;
                v[`SHC_HM_MINS_LSB +: 6]  = s.interval.mins;
            end
            `SHC_ADDR_ACCUM:
            begin
                v[16:0]                    = s.accum.hours;
                v[`SHC_ACC_MINS_LSB +: 6] = s.accum.mins;
            end
            `SHC_ADDR_REMAIN:
            begin
                v[13:0]                    = s.remain.hours;
                v[`SHC_HM_MINS_LSB +: 6]  = s.remain.mins;
            end
            `SHC_ADDR_STATUS:
            begin
                v[`SHC_STAT_ALARM_BIT] = s.alarm;
                v[`SHC_STAT_NEVER_BIT] = s.neverPartial;
                v[`SHC_STAT_RUN_BIT]   = run;
                v[`SHC_STAT_PROG_BIT]  = s.progMode;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : readValue

    // ------------------------------------------------------------------------
    // Submodules: reset edges and minute timebase
    // ------------------------------------------------------------------------
    shc_rise_det uPartialEdge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (partialReset),
        .rise  (partialRise)
    );

    shc_rise_det uFullEdge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (fullReset),
        .rise  (fullRise)
    );

    shc_minute_div #(
        .CYCLES (MINUTE_CYCLES),
        .CW     (DIV_W)
    ) uMinuteDiv (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tickIf (tickIf.src)
    );

    // Timebase frozen in programming mode
    assign tickIf.enable = !s_q.progMode;

    // ------------------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------------------
    // Bus handshake and byte-lane merge
    assign busReq   = avs_read || avs_write;
    assign busWrite = avs_write && s_q.busAck;
    assign beMask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval     = (readValue(avs_address, s_q, runMonitorIn) & ~beMask)
                    | (avs_writedata & beMask);
    assign accWrite = busWrite && (avs_address == `SHC_ADDR_ACCUM);
    assign accWrVal = clampAccum(wval);

    // Interval source: own register or another block's live value
    assign miEff    = s_q.extSelect ? clampIval({10'h000, extIntervalMins, 2'h0,  // [R15]
                                                 extIntervalHours})
                                    : s_q.interval;
    assign miChange = (miEff != s_q.miPrev);
    assign progFall = s_q.progPrev && !s_q.progMode;
    assign countEn  = runMonitorIn && tickIf.tick && !s_q.progMode;               // [R04]
    assign accumSat = (s_q.accum.hours >= `SHC_ACCUM_HOURS_MAX);                 // [R10]

    // Alarm clear condition by mode
    assign clearCond = partialReset || fullReset                                 // [R07]
                    || ((s_q.clrMode == SHC_CLR_RESET_RUN) && !runMonitorIn);    // [R06]

    // Time-to-go from interval and run time offset, in minutes
    assign miMin  = 20'(miEff.hours) * `SHC_HOUR_MINS_W20 + 20'(miEff.mins);
    assign otMin  = 23'(s_q.accum.hours) * `SHC_HOUR_MINS_W23 + 23'(s_q.accum.mins);
    assign remMin = (miMin == 20'h00000) ? 20'h00000
                  : miMin - 20'(otMin % 23'(miMin));                             // [R12]
    assign recalc.hours = 14'(remMin / `SHC_HOUR_MINS_W20);
    assign recalc.mins  = 6'(remMin % `SHC_HOUR_MINS_W20);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.busAck   = busReq && !s_q.busAck;
        s_d.miPrev   = miEff;
        s_d.progPrev = s_q.progMode;
        // Read data captured in the wait cycle
        if (busReq && !s_q.busAck)
            s_d.rdata = avs_read ? readValue(avs_address, s_q, runMonitorIn) : 32'h0;
        // Register writes
        if (busWrite)
        begin
            case (avs_address)
                `SHC_ADDR_CTRL:
                begin
                    s_d.progMode  = wval[`SHC_CTRL_PROG_BIT];
                    s_d.clrMode   = wval[`SHC_CTRL_MODE_BIT] ? SHC_CLR_RESET_ONLY
                                                             : SHC_CLR_RESET_RUN;
                    s_d.extSelect = wval[`SHC_CTRL_EXT_BIT];
                end
                `SHC_ADDR_INTERVAL: s_d.interval = clampIval(wval);              // [R08]
                `SHC_ADDR_ACCUM:
                begin
                    if (s_q.progMode)                                            // [R13]
                        s_d.accum = accWrVal;                                    // [R09]
                end
                `SHC_ADDR_REMAIN:
                begin
                    if (s_q.progMode)
                        s_d.remain = clampIval(wval);                            // [R14]
                end
                default: s_d.rdata = s_d.rdata;
            endcase
        end
        // Run time up count, minutes carry into hours
        if (countEn && !accumSat)                                                // [R11]
        begin
            if (s_q.accum.mins >= `SHC_MINS_MAX)
            begin
                s_d.accum.mins  = 6'h00;                                         // [R16]
                s_d.accum.hours = s_q.accum.hours + 17'h00001;
            end
            else
                s_d.accum.mins = s_q.accum.mins + 6'h01;
        end
        if (fullRise)
            s_d.accum = '0;                                                      // [R03]
        // Time-to-go: reload, recalc, follow interval, or count down
        if (partialRise || fullRise)
        begin
            s_d.remain = miEff;                                                  // [R01]
            if (partialRise)
                s_d.neverPartial = 1'b0;
        end
        else if (progFall && s_q.neverPartial)
            s_d.remain = recalc;                                                 // [R12]
        else if (miChange && !s_q.progMode)
            s_d.remain = miEff;                                                  // [R13]
        else if (countEn && (s_q.remain != '0))                                  // [R16]
        begin
            if (s_q.remain.mins == 6'h00)
            begin
                s_d.remain.mins  = `SHC_MINS_MAX;
                s_d.remain.hours = s_q.remain.hours - 14'h0001;
            end
            else
                s_d.remain.mins = s_q.remain.mins - 6'h01;                       // [R04]
        end
        // Alarm: clear wins, otherwise set at zero and hold
        if (clearCond)
            s_d.alarm = 1'b0;                                                    // [R01] [R03]
        else if (s_q.remain == '0)
            s_d.alarm = 1'b1;                                                    // [R05]
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_q              <= '0;
            s_q.neverPartial <= `SHC_NEVER_PARTIAL_RST;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = busReq && !s_q.busAck;
    assign alarmOut        = s_q.alarm;

    // ------------------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_partial_reload;
        partialRise |=> (s_q.remain == $past(miEff)) && !alarmOut;
    endproperty
    a_partial_reload: assert property (p_partial_reload) else $error("partial reload"); // [R01]

    property p_partial_keeps;
        partialRise && !fullRise && !countEn && !accWrite |=> $stable(s_q.accum);
    endproperty
    a_partial_keeps: assert property (p_partial_keeps) else $error("run time moved"); // [R02]

    property p_full_clear;
        fullRise |=> (s_q.accum == '0) && (s_q.remain == $past(miEff)) && !alarmOut;
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("full reset"); // [R03]

    property p_run_advance;
        countEn && (s_q.remain != '0) && !partialRise && !fullRise && !miChange && !progFall
            |=> s_q.remain != $past(s_q.remain);
    endproperty
    a_run_advance: assert property (p_run_advance) else $error("no countdown"); // [R04]

    property p_alarm_set;
        (s_q.remain == '0) && !clearCond |=> alarmOut;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm not set"); // [R05]

    property p_clear_idle;
        (s_q.clrMode == SHC_CLR_RESET_RUN) && !runMonitorIn |=> !alarmOut;
    endproperty
    a_clear_idle: assert property (p_clear_idle) else $error("idle clear"); // [R06]

    property p_hold_only;
        (s_q.clrMode == SHC_CLR_RESET_ONLY) && alarmOut && !partialReset && !fullReset
            |=> alarmOut;
    endproperty
    a_hold_only: assert property (p_hold_only) else $error("alarm dropped"); // [R07]

    property p_range;
        (s_q.interval.hours <= `SHC_IVAL_HOURS_MAX) && (s_q.interval.mins <= `SHC_MINS_MAX);
    endproperty
    a_range: assert property (p_range) else $error("interval out of range"); // [R08]

    property p_preset;
        accWrite && s_q.progMode && !fullRise |=> s_q.accum == $past(accWrVal);
    endproperty
    a_preset: assert property (p_preset) else $error("preset lost"); // [R09]

    property p_saturate;
        accumSat && !fullRise && !accWrite |=> $stable(s_q.accum);
    endproperty
    a_saturate: assert property (p_saturate) else $error("saturation"); // [R10]

    property p_count_in_partial;
        countEn && partialReset && !accumSat && !fullRise |=> s_q.accum != $past(s_q.accum);
    endproperty
    a_count_in_partial: assert property (p_count_in_partial) else $error("count stopped"); // [R11]

    property p_recalc;
        progFall && s_q.neverPartial && !partialRise && !fullRise
            |=> s_q.remain == $past(recalc);
    endproperty
    a_recalc: assert property (p_recalc) else $error("recalc"); // [R12]

    property p_mi_follow;
        miChange && !s_q.progMode && !progFall && !partialRise && !fullRise
            |=> s_q.remain == $past(miEff);
    endproperty
    a_mi_follow: assert property (p_mi_follow) else $error("interval follow"); // [R13]

    property p_runtime_lock;
        accWrite && !s_q.progMode && !countEn && !fullRise |=> $stable(s_q.accum);
    endproperty
    a_runtime_lock: assert property (p_runtime_lock) else $error("runtime preset"); // [R13]

    property p_wrap;
        countEn && !accumSat && !fullRise && (s_q.accum.mins == `SHC_MINS_MAX)
            |=> (s_q.accum.mins == 6'h00)
                && (s_q.accum.hours == 17'($past(s_q.accum.hours) + 17'h00001));
    endproperty
    a_wrap: assert property (p_wrap) else $error("minute wrap"); // [R16]

    property p_floor;
        (s_q.remain == '0) && !partialRise && !fullRise && !miChange && !progFall
            && !s_q.progMode |=> s_q.remain == '0;
    endproperty
    a_floor: assert property (p_floor) else $error("underflow"); // [R16]

    c_alarm_rise: cover property (!alarmOut ##1 alarmOut);
    c_full_reset: cover property (fullRise && (s_q.accum != '0));
    c_recalc:     cover property (progFall && s_q.neverPartial);
endmodule : shc_service_hours

/* File: shc_params.svh */
// Register map, field positions, limits, reset values and timebase figures
`ifndef SHC_PARAMS_SVH
`define SHC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SHC_ADDR_CTRL         5'h00
`define SHC_ADDR_INTERVAL     5'h04
`define SHC_ADDR_ACCUM        5'h08
`define SHC_ADDR_REMAIN       5'h0C
`define SHC_ADDR_STATUS       5'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SHC_CTRL_PROG_BIT     0
`define SHC_CTRL_MODE_BIT     1
`define SHC_CTRL_EXT_BIT      2
`define SHC_HM_MINS_LSB       16
`define SHC_ACC_MINS_LSB      24
`define SHC_STAT_ALARM_BIT    0
`define SHC_STAT_NEVER_BIT    1
`define SHC_STAT_RUN_BIT      2
`define SHC_STAT_PROG_BIT     3

// ----------------------------------------------------------------------------
// Limits, reset values and timebase
// ----------------------------------------------------------------------------
`define SHC_IVAL_HOURS_MAX    14'h270F
`define SHC_ACCUM_HOURS_MAX   17'h1869F
`define SHC_MINS_MAX          6'h3B
`define SHC_HOUR_MINS_W20     20'h0003C
`define SHC_HOUR_MINS_W23     23'h00003C
`define SHC_NEVER_PARTIAL_RST 1'h1
`define SHC_CLK_HZ            64'h0000_0000_05F5_E100
`define SHC_MINUTE_S          64'h0000_0000_0000_003C

`endif

/* File: shc_pkg.sv */
// Types shared by the service hours counter modules
package shc_pkg;

    // ------------------------------------------------------------------------
    // Alarm clear mode
    // ------------------------------------------------------------------------
    typedef enum logic {SHC_CLR_RESET_RUN, SHC_CLR_RESET_ONLY} shc_clr_mode_e;

    // ------------------------------------------------------------------------
    // Hours and minutes values
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [13:0] hours;
        logic [5:0]  mins;
    } shc_ival_s;

    typedef struct packed {
        logic [16:0] hours;
        logic [5:0]  mins;
    } shc_accum_s;

    // ------------------------------------------------------------------------
    // Complete state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic          progMode;
        shc_clr_mode_e clrMode;
        logic          extSelect;
        shc_ival_s     interval;
        shc_accum_s    accum;
        shc_ival_s     remain;
        shc_ival_s     miPrev;
        logic          alarm;
        logic          neverPartial;
        logic          progPrev;
        logic          busAck;
        logic [31:0]   rdata;
    } shc_state_s;

endpackage : shc_pkg

/* File: shc_tick_if.sv */
// Minute timebase link between divider and counter logic
`timescale 1ns/1ps
interface shc_tick_if;
    logic enable;
    logic tick;
    modport src  (input enable, output tick);
    modport sink (output enable, input tick);
endinterface : shc_tick_if

/* File: shc_rise_det.sv */
// Rising edge detector for a synchronous level input
`timescale 1ns/1ps
module shc_rise_det
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Level in, edge out
    input  wire logic level,
    output logic      rise
);
    typedef struct packed {
        logic prev;
    } shc_edge_s;

    shc_edge_s s_q;
    shc_edge_s s_d;

    // Next state
    always_comb
    begin
        s_d      = s_q;
        s_d.prev = level;
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rise = level && !s_q.prev;
endmodule : shc_rise_det

/* File: shc_minute_div.sv */
// Divider making a one-cycle minute enable from the system clock
`timescale 1ns/1ps
module shc_minute_div
#(
    parameter longint unsigned CYCLES = 64'h0000_0001_65A0_BC00,
    parameter int              CW     = 33
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Timebase link
    shc_tick_if.src   tickIf
);
    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } shc_div_s;

    shc_div_s s_q;
    shc_div_s s_d;

    // Count while enabled, pulse on wrap
    always_comb
    begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (tickIf.enable)
        begin
            if (s_q.count >= CW'(CYCLES - 64'h1))
            begin
                s_d.count = '0;
                s_d.tick  = 1'b1;
            end
            else
                s_d.count = s_q.count + CW'(1);
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tickIf.tick = s_q.tick;
endmodule : shc_minute_div

/* File: shc_far_model.sv */
// Far-side program blocks driving the counter's logic inputs
`timescale 1ns/1ps
module shc_far_model
(
    // Requests from the bench
    input  wire logic [2:0]  lvl,
    input  wire logic [13:0] extH,
    // Levels seen by the counter
    output logic             runMonitorIn,
    output logic             partialReset,
    output logic             fullReset,
    output logic [13:0]      extIntervalHours,
    output logic [5:0]       extIntervalMins
);
    // ----
    // Live levels
    // ----
    assign {fullReset, partialReset, runMonitorIn} = lvl;
    assign extIntervalHours = extH;
    assign extIntervalMins  = 6'h00;
endmodule : shc_far_model

/* File: tb_top.sv */
// Self-checking bench for the service hours counter
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        alarm;
    logic [2:0]  lvl = 3'h0;
    logic [13:0] extH = 14'h0;
    logic        run, pr, fr;
    logic [13:0] eh;
    logic [5:0]  em;
    logic [31:0] v;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    // Address, write data, expected read back
    localparam logic [68:0] ROWS [4] = '{
        {5'h04, 32'h003F_3FFF, 32'h003B_270F},
        {5'h08, 32'h0100_0001, 32'h0000_0000},
        {5'h14, 32'hFFFF_FFFF, 32'h0000_0000},
        {5'h04, 32'h0005_0003, 32'h0005_0003}};

    // ----
    // Clock, timeout, design and far side
    // ----
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            conclude();
        end
    end
    shc_service_hours #(.MINUTE_CYCLES(16)) i_shc_service_hours (.mclk(mclk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .runMonitorIn(run), .partialReset(pr), .fullReset(fr),
        .extIntervalHours(eh), .extIntervalMins(em), .alarmOut(alarm));
    shc_far_model i_shc_far_model (.lvl(lvl), .extH(extH), .runMonitorIn(run),
        .partialReset(pr), .fullReset(fr), .extIntervalHours(eh), .extIntervalMins(em));

    // ----
    // Bus access, checks and closing
    // ----
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        do
            @(posedge mclk);
        while (wreq !== 1'b0);
        v  = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(v, e)
    endtask : rdChk
    task automatic waitAlarm(input logic e);
        int n;
        n = 0;
        while (alarm !== e && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        `CHK(alarm, e)
    endtask : waitAlarm
    task automatic pulse(input logic [2:0] l);
        @(posedge mclk);
        lvl <= l;
        repeat (3) @(posedge mclk);
        lvl <= 3'h0;
    endtask : pulse
    task automatic note(input string s);
        $display("Test %s done at %0t", s, $time);
    endtask : note
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rdChk(5'h10, 32'h0000_0002);
        `CHK(alarm, 1'b0)
        note("reset");
        foreach (ROWS[i])
        begin
            bus(1'b1, ROWS[i][68:64], ROWS[i][63:32]);
            rdChk(ROWS[i][68:64], ROWS[i][31:0]);
        end
        note("rows");
        bus(1'b1, 5'h00, 32'h3);
        bus(1'b1, 5'h04, 32'h0003_0000);
        bus(1'b1, 5'h08, 32'h0700_0000);
        rdChk(5'h08, 32'h0700_0000);
        bus(1'b1, 5'h00, 32'h2);
        rdChk(5'h0C, 32'h0002_0000);
        note("preset");
        lvl <= 3'h1;
        waitAlarm(1'b1);
        repeat (20) @(posedge mclk);
        lvl <= 3'h0;
        rdChk(5'h0C, 32'h0);
        rdChk(5'h08, 32'h0A00_0000);
        `CHK(alarm, 1'b1)
        pulse(3'h2);
        waitAlarm(1'b0);
        rdChk(5'h0C, 32'h0003_0000);
        rdChk(5'h08, 32'h0A00_0000);
        note("partial");
        bus(1'b1, 5'h00, 32'h0);
        lvl <= 3'h1;
        waitAlarm(1'b1);
        lvl <= 3'h0;
        repeat (2) @(posedge mclk);
        `CHK(alarm, 1'b0)
        pulse(3'h4);
        rdChk(5'h08, 32'h0);
        rdChk(5'h0C, 32'h0003_0000);
        bus(1'b1, 5'h04, 32'h2);
        rdChk(5'h0C, 32'h2);
        extH <= 14'h3FFF;
        bus(1'b1, 5'h00, 32'h4);
        rdChk(5'h0C, 32'h270F);
        note("full");
        lvl <= 3'h3;
        repeat (16) @(posedge mclk);
        lvl <= 3'h0;
        rdChk(5'h08, 32'h0100_0000);
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b1, 5'h08, 32'h0001_FFFF);
        bus(1'b1, 5'h00, 32'h0);
        lvl <= 3'h1;
        repeat (40) @(posedge mclk);
        lvl <= 3'h0;
        rdChk(5'h08, 32'h0001_869F);
        note("limits");
        conclude();
    end
endmodule : tb_top
